// [rtl/eic_pkg.sv]
// Constants, tables and types shared by the encoder configuration and status logic
// How it works
// - Third select high: first and second selects pick 10X to 32X.
// - Third select open: first and second selects pick 50X to 512X.
// - Index gate select picks 90, 180 or 360 degree index gating; open at 1X gives unavailable code 10.
// - All selects open enters serial mode; index select picks programming or output.
// - Serially programmed factor accepted from 1 up to 1024.
// - Frame is 16 bits: command bit, seven address bits, data byte.
// - Read frame has command zero; device returns the addressed byte.
// - Key 0xab at 0x10 unlocks, then 0x00 at 0x14 selects page zero.
// - Key 0xa1 written to 0x11 stores settings into program memory.
// - 11-bit factor: top three bits in 0x0b, low byte in 0x0c.
// - Two-bit width code in 0x0b: 00, 01, 11 valid; 10 unavailable.
// - Calibration request high at power-up starts autocalibration.
// - During calibration A+ and B+ report progress codes; I+ is held low.
// - Host releases request and cycles power to resume normal operation.
// - Calibration indicator blinks 500 ms, high when done, low on error.
// - Indicators low from power-up; operation indicator high once ready.
// - Fault indicator high at maximum light current, blinks on warning.
// - Off-scale fault forces A+ high, A- low, B+ high, B- low, I+ low, I- high.
// - Serial clock, data in, data out share B-, A- and I+ pins.
// - Outputs invalid until channel A or B first toggles.

package eic_pkg;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_HZ            = 25_000_000;
    localparam int BLINK_PERIOD_MS   = 500;
    localparam int BLINK_HALF_CYCLES = (BLINK_PERIOD_MS / 2) * (CLK_HZ / 1000);
    localparam logic [1:0] STRAP_WAIT = 2'h3;

    // ----------------------------------------
    // Three-level pin codes
    // ----------------------------------------
    localparam logic [1:0] LVL_LOW  = 2'h0;
    localparam logic [1:0] LVL_HIGH = 2'h1;
    localparam logic [1:0] LVL_OPEN = 2'h2;

    // ----------------------------------------
    // Register map and keys
    // ----------------------------------------
    localparam logic [6:0] REG_INTERP_HI = 7'h0b;
    localparam logic [6:0] REG_INTERP_LO = 7'h0c;
    localparam logic [6:0] REG_UNLOCK    = 7'h10;
    localparam logic [6:0] REG_COMMIT    = 7'h11;
    localparam logic [6:0] REG_PAGE      = 7'h14;
    localparam logic [7:0] UNLOCK_KEY    = 8'hab;
    localparam logic [7:0] COMMIT_KEY    = 8'ha1;
    localparam logic [7:0] PAGE_ZERO     = 8'h00;
    localparam int INTERP_HI_LSB = 0;
    localparam int WIDTH_LSB     = 3;

    // ----------------------------------------
    // Frame layout
    // ----------------------------------------
    localparam int CMD_BIT = 15;
    localparam logic [3:0] HDR_LAST   = 4'h7;
    localparam logic [3:0] FRAME_LAST = 4'hf;

    // ----------------------------------------
    // Factors, widths and reset values
    // ----------------------------------------
    localparam logic [10:0] INTERP_MIN = 11'h001;
    localparam logic [10:0] INTERP_MAX = 11'h400;
    localparam logic [1:0] IW_90  = 2'h0;
    localparam logic [1:0] IW_180 = 2'h1;
    localparam logic [1:0] IW_NA  = 2'h2;
    localparam logic [1:0] IW_360 = 2'h3;
    localparam logic [10:0] RST_INTERP = 11'h010;
    localparam logic [1:0]  RST_WIDTH  = 2'h0;
    localparam logic [10:0] PIN_FACTORS [27] = '{
        11'h001, 11'h002, 11'h003, 11'h004, 11'h005, 11'h006, 11'h007, 11'h008, 11'h009,
        11'h00a, 11'h00c, 11'h00e, 11'h00f, 11'h010, 11'h012, 11'h014, 11'h019, 11'h020,
        11'h032, 11'h040, 11'h050, 11'h064, 11'h080, 11'h0a0, 11'h100, 11'h200, 11'h000};

    // ----------------------------------------
    // Operating modes
    // ----------------------------------------
    typedef enum logic [3:0] {
        MODE_PIN  = 4'h1,
        MODE_PROG = 4'h2,
        MODE_SOUT = 4'h4,
        MODE_CAL  = 4'h8
    } eic_mode_t;

endpackage : eic_pkg

// [rtl/eic_sync.sv]
// Two-stage synchroniser for inputs arriving from outside the clock domain
`timescale 1ns/10ps
`default_nettype none

module eic_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // Data
    input  wire logic [WIDTH-1:0] d,
    output var  logic [WIDTH-1:0] q
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } eic_sync_t;

    eic_sync_t s_r;
    eic_sync_t s_nxt;

    // First stage feeds only the second stage
    always_comb begin
        s_nxt    = s_r;
        s_nxt.s1 = d;
        s_nxt.s2 = s_r.s1;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign q = s_r.s2;

endmodule : eic_sync

`default_nettype wire

// [rtl/eic_top.sv]
// Encoder select decode, serial configuration port, calibration and status outputs
`timescale 1ns/10ps
`default_nettype none

module eic_top
    import eic_pkg::*;
#(
    parameter int unsigned BLINK_HALF = BLINK_HALF_CYCLES
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // Three-level select pins and calibration request pin
    input  wire logic [1:0]  factor_pick_first,
    input  wire logic [1:0]  factor_pick_second,
    input  wire logic [1:0]  factor_pick_third,
    input  wire logic [1:0]  index_gate_pick,
    input  wire logic        cal_request,
    // Interpolator core and light source monitor
    input  wire logic        core_a,
    input  wire logic        core_b,
    input  wire logic        core_index,
    input  wire logic        light_max_current,
    input  wire logic        light_high_warning,
    // Calibration engine
    input  wire logic        cal_inc_done,
    input  wire logic        cal_index_done,
    input  wire logic        cal_error,
    output var  logic        cal_run,
    // Encoder pins
    output var  logic        quadrature_a_true,
    output var  logic        quadrature_a_comp_out,
    output var  logic        quadrature_a_comp_oe_n,
    input  wire logic        quadrature_a_comp_in,
    output var  logic        quadrature_b_true,
    output var  logic        quadrature_b_comp_out,
    output var  logic        quadrature_b_comp_oe_n,
    input  wire logic        quadrature_b_comp_in,
    output var  logic        index_true,
    output var  logic        index_comp,
    // Status indicators
    output var  logic        operation_indicator,
    output var  logic        calibration_indicator,
    output var  logic        light_source_fault,
    // Configuration to interpolator core
    output var  logic [10:0] interp_factor,
    output var  logic [1:0]  index_width,
    output var  logic        commit_strobe
);

    // ----------------------------------------
    // Synchronised inputs
    // ----------------------------------------
    localparam int BW = $clog2(BLINK_HALF + 1);
    localparam logic [BW-1:0] BLINK_LAST = BW'(BLINK_HALF - 1);

    logic [15:0] pins_s;
    logic [1:0]  factor_pick_first_s;
    logic [1:0]  factor_pick_second_s;
    logic [1:0]  factor_pick_third_s;
    logic [1:0]  isel_s;
    logic        cal_s;
    logic        sdin_s;
    logic        sclk_s;
    logic        a_s;
    logic        b_s;
    logic        i_s;
    logic        fmax_s;
    logic        fwarn_s;

    eic_sync #(
        .WIDTH (16)
    ) u_sync (
        .clk   (clk),
        .reset (reset),
        .d     ({factor_pick_first, factor_pick_second, factor_pick_third, index_gate_pick,
                 cal_request, quadrature_a_comp_in, quadrature_b_comp_in, core_a, core_b,
                 core_index, light_max_current, light_high_warning}),
        .q     (pins_s)
    );

    assign {factor_pick_first_s, factor_pick_second_s, factor_pick_third_s, isel_s, cal_s, sdin_s, sclk_s, a_s, b_s, i_s, fmax_s, fwarn_s} = pins_s;

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    // Undefined pin code 11 is read as open
    function automatic logic [1:0] lvl(input logic [1:0] x);
        return (x == 2'h3) ? LVL_OPEN : x;
    endfunction

    function automatic logic [4:0] pin_row(input logic [1:0] p1, input logic [1:0] p2, input logic [1:0] p3);
        logic [4:0] r;
        r = {3'h0, lvl(p1)} + 5'h03 * {3'h0, lvl(p2)} + 5'h09 * {3'h0, lvl(p3)};
        return r;
    endfunction

    function automatic logic [1:0] pin_width(input logic [1:0] p);
        unique case (lvl(p))
            LVL_LOW:  return IW_90;
            LVL_HIGH: return IW_180;
            default:  return IW_360;
        endcase
    endfunction

    function automatic logic [7:0] read_reg(input logic [6:0] a, input logic [10:0] f, input logic [1:0] w);
        logic [7:0] v;
        v = 8'h00;
        if (a == REG_INTERP_HI) begin
            v[INTERP_HI_LSB +: 3] = f[10:8];
            v[WIDTH_LSB +: 2]     = w;
        end else if (a == REG_INTERP_LO) begin
            v = f[7:0];
        end
        return v;
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        eic_mode_t        mode;
        logic [1:0]       pwr_cnt;
        logic             strap_done;
        logic             cal_active;
        logic             sclk_prev;
        logic [3:0]       bitcnt;
        logic [15:0]      shift;
        logic             rd_active;
        logic [7:0]       rd_byte;
        logic             unlocked;
        logic [7:0]       page;
        logic [10:0]      sh_interp;
        logic [1:0]       sh_width;
        logic [10:0]      mem_interp;
        logic [1:0]       mem_width;
        logic             commit;
        logic             a_prev;
        logic             b_prev;
        logic             valid;
        logic [BW-1:0]    blink_cnt;
        logic             blink;
        logic             a_t;
        logic             a_n;
        logic             a_oe_n;
        logic             b_t;
        logic             b_n;
        logic             b_oe_n;
        logic             i_t;
        logic             i_n;
        logic             op_ind;
        logic             cal_ind;
        logic             fault_ind;
        logic [10:0]      interp;
        logic [1:0]       width;
        logic             cal_run;
    } eic_state_t;

    eic_state_t s_r;
    eic_state_t s_nxt;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic [15:0] frame;
        logic        rise;
        logic        fall;
        logic        reg_open;
        logic        cal_ok;
        frame    = {s_r.shift[14:0], sdin_s};
        rise     = sclk_s & ~s_r.sclk_prev;
        fall     = ~sclk_s & s_r.sclk_prev;
        reg_open = s_r.unlocked && (s_r.page == PAGE_ZERO);
        cal_ok   = cal_inc_done && cal_index_done && !cal_error;
        s_nxt    = s_r;
        s_nxt.sclk_prev = sclk_s;
        s_nxt.commit    = 1'b0;

        // Strap is caught only after the synchroniser has filled
        if (!s_r.strap_done) begin
            s_nxt.pwr_cnt = s_r.pwr_cnt + 2'h1;
            s_nxt.a_prev  = a_s;
            s_nxt.b_prev  = b_s;
            if (s_r.pwr_cnt == STRAP_WAIT) begin
                s_nxt.strap_done = 1'b1;
                s_nxt.cal_active = cal_s;
            end
        end

        // Calibration holds until power is cycled
        if (s_r.cal_active) begin
            s_nxt.mode = MODE_CAL;
        end else if (lvl(factor_pick_first_s) == LVL_OPEN && lvl(factor_pick_second_s) == LVL_OPEN && lvl(factor_pick_third_s) == LVL_OPEN) begin
            s_nxt.mode = (lvl(isel_s) == LVL_LOW) ? MODE_PROG : MODE_SOUT;
        end else begin
            s_nxt.mode = MODE_PIN;
        end

        // Serial engine, MSB first, sampled on rising serial clock
        if (s_r.mode == MODE_PROG) begin
            if (rise) begin
                s_nxt.shift  = frame;
                s_nxt.bitcnt = s_r.bitcnt + 4'h1;
                if (s_r.bitcnt == HDR_LAST) begin
                    s_nxt.rd_active = ~frame[7];
                    s_nxt.rd_byte   = read_reg(frame[6:0], s_r.sh_interp, s_r.sh_width);
                end
                if (s_r.bitcnt == FRAME_LAST) begin
                    s_nxt.bitcnt    = 4'h0;
                    s_nxt.rd_active = 1'b0;
                    if (frame[CMD_BIT]) begin
                        if (frame[14:8] == REG_UNLOCK) begin
                            s_nxt.unlocked = (frame[7:0] == UNLOCK_KEY);
                        end else if (frame[14:8] == REG_PAGE) begin
                            s_nxt.page = frame[7:0];
                        end else if (frame[14:8] == REG_INTERP_HI && reg_open) begin
                            s_nxt.sh_interp[10:8] = frame[INTERP_HI_LSB +: 3];
                            s_nxt.sh_width        = frame[WIDTH_LSB +: 2];
                        end else if (frame[14:8] == REG_INTERP_LO && reg_open) begin
                            s_nxt.sh_interp[7:0] = frame[7:0];
                        end else if (frame[14:8] == REG_COMMIT && reg_open && frame[7:0] == COMMIT_KEY
                                     && s_r.sh_interp >= INTERP_MIN && s_r.sh_interp <= INTERP_MAX
                                     && s_r.sh_width != IW_NA) begin
                            s_nxt.mem_interp = s_r.sh_interp;
                            s_nxt.mem_width  = s_r.sh_width;
                            s_nxt.commit     = 1'b1;
                        end
                    end
                end
            end
            if (fall && s_r.rd_active) begin
                s_nxt.i_t     = s_r.rd_byte[7];
                s_nxt.rd_byte = {s_r.rd_byte[6:0], 1'b0};
            end
        end else begin
            s_nxt.bitcnt    = 4'h0;
            s_nxt.rd_active = 1'b0;
        end

        // First channel toggle marks outputs valid
        if (s_r.strap_done && (a_s != s_r.a_prev || b_s != s_r.b_prev)) begin
            s_nxt.valid = 1'b1;
        end
        if (s_r.strap_done) begin
            s_nxt.a_prev = a_s;
            s_nxt.b_prev = b_s;
        end

        // Shared half-period divider for both blinking indicators
        if (s_r.blink_cnt == BLINK_LAST) begin
            s_nxt.blink_cnt = '0;
            s_nxt.blink     = ~s_r.blink;
        end else begin
            s_nxt.blink_cnt = s_r.blink_cnt + BW'(1);
        end

        // Active configuration
        if (s_r.mode == MODE_PIN) begin
            s_nxt.interp = PIN_FACTORS[pin_row(factor_pick_first_s, factor_pick_second_s, factor_pick_third_s)];
            s_nxt.width  = (lvl(factor_pick_third_s) == LVL_LOW && lvl(factor_pick_first_s) == LVL_LOW && lvl(factor_pick_second_s) == LVL_LOW
                            && lvl(isel_s) == LVL_OPEN) ? IW_NA : pin_width(isel_s);
        end else begin
            s_nxt.interp = s_r.mem_interp;
            s_nxt.width  = s_r.mem_width;
        end
        s_nxt.cal_run = s_r.cal_active && !cal_ok && !cal_error;

        // Pin drivers
        s_nxt.a_oe_n = 1'b0;
        s_nxt.b_oe_n = 1'b0;
        if (s_r.mode == MODE_CAL) begin
            s_nxt.a_t = cal_error || (cal_inc_done && !cal_index_done);
            s_nxt.b_t = cal_error || (cal_inc_done && cal_index_done);
            s_nxt.i_t = 1'b0;
            s_nxt.a_n = 1'b0;
            s_nxt.b_n = 1'b0;
            s_nxt.i_n = 1'b0;
        end else if (s_r.mode == MODE_PROG) begin
            // Complement pins become serial clock and data inputs
            s_nxt.a_oe_n = 1'b1;
            s_nxt.b_oe_n = 1'b1;
            s_nxt.a_t    = 1'b0;
            s_nxt.b_t    = 1'b0;
            s_nxt.i_n    = 1'b0;
            if (!s_r.rd_active && !fall) begin
                s_nxt.i_t = 1'b0;
            end
        end else if (fmax_s) begin
            s_nxt.a_t = 1'b1;
            s_nxt.a_n = 1'b0;
            s_nxt.b_t = 1'b1;
            s_nxt.b_n = 1'b0;
            s_nxt.i_t = 1'b0;
            s_nxt.i_n = 1'b1;
        end else if (!s_r.valid) begin
            s_nxt.a_t = 1'b0;
            s_nxt.a_n = 1'b0;
            s_nxt.b_t = 1'b0;
            s_nxt.b_n = 1'b0;
            s_nxt.i_t = 1'b0;
            s_nxt.i_n = 1'b0;
        end else begin
            s_nxt.a_t = a_s;
            s_nxt.a_n = ~a_s;
            s_nxt.b_t = b_s;
            s_nxt.b_n = ~b_s;
            s_nxt.i_t = i_s;
            s_nxt.i_n = ~i_s;
        end

        // Status indicators
        s_nxt.op_ind    = s_r.valid && !s_r.cal_active && !fmax_s && !fwarn_s;
        s_nxt.cal_ind   = s_r.cal_active && !cal_error && (cal_ok || s_r.blink);
        s_nxt.fault_ind = !s_r.cal_active && (fmax_s || (fwarn_s && s_r.blink));
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_r            <= '0;
            s_r.mode       <= MODE_PIN;
            s_r.mem_interp <= RST_INTERP;
            s_r.mem_width  <= RST_WIDTH;
            s_r.interp     <= RST_INTERP;
            s_r.width      <= RST_WIDTH;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign quadrature_a_true      = s_r.a_t;
    assign quadrature_a_comp_out  = s_r.a_n;
    assign quadrature_a_comp_oe_n = s_r.a_oe_n;
    assign quadrature_b_true      = s_r.b_t;
    assign quadrature_b_comp_out  = s_r.b_n;
    assign quadrature_b_comp_oe_n = s_r.b_oe_n;
    assign index_true             = s_r.i_t;
    assign index_comp             = s_r.i_n;
    assign operation_indicator    = s_r.op_ind;
    assign calibration_indicator  = s_r.cal_ind;
    assign light_source_fault     = s_r.fault_ind;
    assign interp_factor          = s_r.interp;
    assign index_width            = s_r.width;
    assign commit_strobe          = s_r.commit;
    assign cal_run                = s_r.cal_run;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_fault_force;
        fmax_s && s_r.mode != MODE_CAL && s_r.mode != MODE_PROG |=>
            quadrature_a_true && !quadrature_a_comp_out && quadrature_b_true && !quadrature_b_comp_out
            && !index_true && index_comp;
    endproperty
    a_fault_force: assert property (p_fault_force) else $error("fault pattern not forced");

    property p_prog_release;
        s_r.mode == MODE_PROG |=> quadrature_a_comp_oe_n && quadrature_b_comp_oe_n;
    endproperty
    a_prog_release: assert property (p_prog_release) else $error("complement pins driven in programming");

    property p_factor_16;
        s_r.mode == MODE_PIN && !s_r.cal_active && factor_pick_first_s == LVL_HIGH && factor_pick_second_s == LVL_HIGH
            && factor_pick_third_s == LVL_HIGH |=> interp_factor == 11'h010;
    endproperty
    a_factor_16: assert property (p_factor_16) else $error("pin factor 16 wrong");

    property p_factor_512;
        s_r.mode == MODE_PIN && !s_r.cal_active && factor_pick_first_s == LVL_HIGH && factor_pick_second_s == LVL_OPEN
            && factor_pick_third_s == LVL_OPEN |=> interp_factor == 11'h200;
    endproperty
    a_factor_512: assert property (p_factor_512) else $error("pin factor 512 wrong");

    property p_width_high;
        s_r.mode == MODE_PIN && isel_s == LVL_HIGH |=> index_width == IW_180;
    endproperty
    a_width_high: assert property (p_width_high) else $error("index width 180 wrong");

    property p_ready;
        $rose(operation_indicator) |-> s_r.valid && !calibration_indicator && !light_source_fault;
    endproperty
    a_ready: assert property (p_ready) else $error("ready shown while invalid");

    property p_cal_error;
        s_r.mode == MODE_CAL && cal_error |=> !calibration_indicator && quadrature_a_true
            && quadrature_b_true && !index_true;
    endproperty
    a_cal_error: assert property (p_cal_error) else $error("calibration error not reported");

    property p_commit;
        commit_strobe |-> $past(s_r.unlocked) && $past(s_r.page) == PAGE_ZERO
            && s_r.mem_interp == s_r.sh_interp && s_r.mem_interp <= INTERP_MAX && s_r.mem_width != IW_NA;
    endproperty
    a_commit: assert property (p_commit) else $error("commit without unlock or bad value");

    property p_sout_cfg;
        s_r.mode == MODE_SOUT ##1 s_r.mode == MODE_SOUT |-> interp_factor == $past(s_r.mem_interp);
    endproperty
    a_sout_cfg: assert property (p_sout_cfg) else $error("serial output mode not using stored factor");

    c_commit: cover property (commit_strobe);
    c_cal_done: cover property (s_r.cal_active && calibration_indicator && !s_r.cal_run);
    c_read: cover property (s_r.rd_active ##1 !s_r.rd_active);
    c_warn: cover property (fwarn_s && !fmax_s && light_source_fault);

endmodule : eic_top

`default_nettype wire

// [tb/eic_host.sv]
// Host model driving the serial configuration link
`timescale 1ns/10ps
`default_nettype none
module eic_host (
    // Link
    input  wire logic clk,
    output var  logic sclk,
    output var  logic sdo,
    input  wire logic sdi
);
    initial {sclk, sdo} = 2'b10;
    // Idle high; eight clk a bit runs the link at 3.125 MHz
    task automatic fr(input logic [15:0] f, output logic [7:0] rd);
        @(posedge clk);
        for (int i = 15; i >= 0; i--) begin
            {sclk, sdo} <= {1'b0, f[i]};
            repeat (4) @(posedge clk);
            sclk <= 1'b1;
            repeat (4) @(posedge clk);
            if (i < 8) rd[i] = sdi;
        end
        sdo <= ~f[0];
        repeat (8) @(posedge clk);
    endtask
endmodule // eic_host
`default_nettype wire

// [tb/tb.sv]
// Bench for the encoder configuration block
`timescale 1ns/10ps
`default_nettype none
module tb;
    import eic_pkg::*;
    localparam logic [10:0] FTAB [13] = '{11'h010, 11'h012, 11'h014, 11'h019, 11'h020, 11'h032, 11'h040,
        11'h050, 11'h064, 11'h080, 11'h0a0, 11'h100, 11'h200};
    localparam logic [14:0] WSEQ [4] = '{{REG_UNLOCK, UNLOCK_KEY}, {REG_PAGE, PAGE_ZERO},
        {REG_INTERP_HI, 8'h1c}, {REG_COMMIT, 8'ha2}};
    localparam int BH = 8;
    int err_total = 0, num_checks = 0, cyc = 0, ncom = 0, k, v, tg;
    logic [31:0] rs = 32'h3fdf;
    logic [7:0] rd;
    logic [1:0] s1 = 2'h0, s2 = 2'h0, s3 = 2'h0, ix = 2'h0, iw;
    logic clk = 1'b0, reset = 1'b1, ca = 1'b0, cb = 1'b0, ci = 1'b0, lm = 1'b0;
    logic lw = 1'b0, cr = 1'b0, cid = 1'b0, cxd = 1'b0, cer = 1'b0;
    logic hclk, hdo, qat, qac, qan, qbt, qbc, qbn, it, ic, opi, lsf, cs, cal_ind, crun;
    logic [10:0] ifac;
    eic_top #(.BLINK_HALF(BH)) dut (.clk, .reset, .factor_pick_first(s1), .factor_pick_second(s2),
        .factor_pick_third(s3), .index_gate_pick(ix), .cal_request(cr), .core_a(ca), .core_b(cb),
        .core_index(ci), .light_max_current(lm), .light_high_warning(lw), .cal_inc_done(cid),
        .cal_index_done(cxd), .cal_error(cer), .cal_run(crun), .quadrature_a_true(qat),
        .quadrature_a_comp_out(qac), .quadrature_a_comp_oe_n(qan), .quadrature_a_comp_in(qan ? hdo : qac),
        .quadrature_b_true(qbt), .quadrature_b_comp_out(qbc), .quadrature_b_comp_oe_n(qbn),
        .quadrature_b_comp_in(qbn ? hclk : qbc), .index_true(it), .index_comp(ic),
        .operation_indicator(opi), .calibration_indicator(cal_ind), .light_source_fault(lsf),
        .interp_factor(ifac), .index_width(iw), .commit_strobe(cs));
    eic_host h (.clk, .sclk(hclk), .sdo(hdo), .sdi(it));
    initial forever #20 clk = ~clk;
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    task automatic chk(input logic [15:0] s, input logic [15:0] w);
        num_checks++;
        err_total += int'(s !== w);
        if (s !== w)
            $display("wrong value %0t: %h not %h", $time, s, w);
    endtask
    // Counts level changes of one indicator over 32 clock intervals
    task automatic blinks(input bit pick, output int t);
        logic p, q;
        t = 0;
        p = pick ? cal_ind : lsf;
        repeat (32) begin
            @(posedge clk);
            q = pick ? cal_ind : lsf;
            t += int'(q !== p);
            p = q;
        end
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        ncom += int'(cs === 1'b1);
        err_total += int'(++cyc == 5000);
        if (cyc == 5000)
            complete_run();
    end
    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        for (int n = 0; n < 30; n++) begin
            rs = xs(rs);
            k = n < 2 ? n * 12 : int'(rs % 13);
            v = k < 5 ? k + 4 : k - 5;
            s3 <= k < 5 ? LVL_HIGH : LVL_OPEN;
            {s2, s1, ix} <= {2'(v / 3), 2'(v % 3), 2'(rs[9:8] % 3)};
            repeat (9) @(posedge clk);
            chk(16'(ifac), 16'(FTAB[k]));
            chk(16'(iw), 16'(ix == LVL_OPEN ? IW_360 : ix));
        end
        {ca, ci} <= 2'b11;
        repeat (9) @(posedge clk);
        chk(16'({qat, qac, it, ic, opi}), 16'h15);
        lm <= 1'b1;
        repeat (9) @(posedge clk);
        chk(16'({qat, qac, qbt, qbc, it, ic, lsf, opi}), 16'ha6);
        {lm, lw} <= 2'b01;
        repeat (9) @(posedge clk);
        blinks(1'b0, tg);
        chk(16'(tg), 16'(32 / BH));
        chk(16'(opi), 16'h0);
        // Fault cleared first, so the released clock pin shows no false rise
        {s1, s2, s3, ix, lw} <= {LVL_OPEN, LVL_OPEN, LVL_OPEN, LVL_LOW, 1'b0};
        repeat (6) @(posedge clk);
        // Locked write must not land, so the low byte stays clear
        h.fr({1'b1, REG_INTERP_LO, 8'h5a}, rd);
        foreach (WSEQ[j]) h.fr({1'b1, WSEQ[j]}, rd);
        h.fr({1'b0, REG_INTERP_HI, 8'h00}, rd);
        chk(16'(rd), 16'h1c);
        h.fr({1'b1, REG_COMMIT, COMMIT_KEY}, rd);
        chk(16'(ncom), 16'h1);
        ix <= LVL_HIGH;
        repeat (9) @(posedge clk);
        chk(16'({iw, ifac}), {3'h0, IW_360, 11'h400});
        // Power-up with the calibration strap held high
        {reset, cr} <= 2'b11;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        repeat (40) @(posedge clk);
        chk(16'({qat, qbt, it, opi, lsf, crun}), 16'h01);
        blinks(1'b1, tg);
        chk(16'(tg), 16'(32 / BH));
        cid <= 1'b1;
        repeat (3) @(posedge clk);
        chk(16'({qat, qbt, it}), 16'h4);
        cxd <= 1'b1;
        repeat (3) @(posedge clk);
        chk(16'({qat, qbt, it, cal_ind, crun}), 16'h0a);
        cer <= 1'b1;
        repeat (3) @(posedge clk);
        chk(16'({qat, qbt, it, cal_ind}), 16'hc);
        // Strap released and power cycled: normal outputs after the first toggle
        {reset, cr, cid, cxd, cer} <= 5'h10;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        repeat (12) @(posedge clk);
        chk(16'({qat, qbt, it, opi}), 16'h0);
        cb <= 1'b1;
        repeat (9) @(posedge clk);
        chk(16'({qbt, qbc, cal_ind, crun, ifac}), {5'h08, RST_INTERP});
        complete_run();
    end
endmodule // tb
`default_nettype wire
